// *** tc_pkg.sv ***
// Purpose: Shared constants for the dual-slope PWM timer and its prescaler.
// Assumes: Byte-wide registers on a plain strobe port, one word per aligned address.
// Notes:   Offsets, field positions, reset values and cycle counts live here only.
package tc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte addresses.
	localparam logic [7:0] OFS_CTRL_A    = 8'h00; // Output actions and low mode bits.
	localparam logic [7:0] OFS_CTRL_B    = 8'h04; // High mode bit and clock select.
	localparam logic [7:0] OFS_COUNT     = 8'h08; // Counter value.
	localparam logic [7:0] OFS_CMP_A     = 8'h0C; // Compare value A.
	localparam logic [7:0] OFS_CMP_B     = 8'h10; // Compare value B.
	localparam logic [7:0] OFS_ASYNC     = 8'h14; // Clock source select and busy flags.
	localparam logic [7:0] OFS_INT_FLAGS = 8'h18; // Event flags, write one to clear.
	localparam logic [7:0] OFS_INT_MASK  = 8'h1C; // Event enables.

	////////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int ACT_A_LSB      = 6; // Output action A in the first control register.
	localparam int ACT_B_LSB      = 4; // Output action B in the first control register.
	localparam int WAVE_LO_LSB    = 0; // Two low mode bits in the first control register.
	localparam int WAVE_HI_BIT    = 3; // High mode bit in the second control register.
	localparam int CLK_SEL_LSB    = 0; // Clock select in the second control register.
	localparam int ASYNC_SEL_BIT  = 5; // Oscillator clock select in the status register.
	localparam int FLAG_OVF       = 0; // Overflow flag position.
	localparam int FLAG_CMP_A     = 1; // Compare A flag position.
	localparam int FLAG_CMP_B     = 2; // Compare B flag position.

	////////////////////////////////////////////////////////////////////////////
	// Holding-register slots; a slot number is also its busy bit position.
	localparam int NUM_SLOTS      = 5;
	localparam logic [2:0] SLOT_CTRL_B = 3'h0;
	localparam logic [2:0] SLOT_CTRL_A = 3'h1;
	localparam logic [2:0] SLOT_CMP_B  = 3'h2;
	localparam logic [2:0] SLOT_CMP_A  = 3'h3;
	localparam logic [2:0] SLOT_COUNT  = 3'h4;
	localparam logic [2:0] SLOT_NONE   = 3'h7;

	////////////////////////////////////////////////////////////////////////////
	// Values after reset, modes and limits.
	localparam logic [7:0] RST_BYTE       = 8'h00;
	localparam logic [2:0] RST_FLAGS      = 3'h0;
	localparam logic [2:0] WAVE_DUAL_MAX  = 3'h1; // Dual slope, top fixed at maximum.
	localparam logic [2:0] WAVE_DUAL_CMPA = 3'h5; // Dual slope, top from compare A.
	localparam logic [1:0] ACT_CLEAR_UP   = 2'h2; // Non-inverting output action.
	localparam logic [1:0] ACT_SET_UP     = 2'h3; // Inverting output action.
	localparam logic [7:0] TOP_MAX        = 8'hFF;
	localparam logic [7:0] BOTTOM         = 8'h00;
	localparam int PERIOD_TICKS_MAX       = 510;  // Ticks in one period with top at maximum.
	localparam logic [1:0] COMMIT_EDGES   = 2'h2; // Oscillator edges before a commit.
	localparam int IRQ_SYNC_CYCLES        = 3;    // Processor cycles to carry a flag across.

	////////////////////////////////////////////////////////////////////////////
	// Clock select codes and prescaler tap masks.
	localparam logic [2:0] CLK_STOP = 3'h0;
	localparam logic [9:0] PRE_MASK_1    = 10'h000;
	localparam logic [9:0] PRE_MASK_8    = 10'h007;
	localparam logic [9:0] PRE_MASK_32   = 10'h01F;
	localparam logic [9:0] PRE_MASK_64   = 10'h03F;
	localparam logic [9:0] PRE_MASK_128  = 10'h07F;
	localparam logic [9:0] PRE_MASK_256  = 10'h0FF;
	localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
	localparam logic [9:0] RST_PRE       = 10'h000;

	// Counting direction of the dual-slope counter.
	typedef enum logic [1:0] {
		DIR_UP   = 2'b01,
		DIR_DOWN = 2'b10
	} dir_e;

endpackage

// *** tick_prescaler.sv ***
// Purpose: Divides the source tick by the selected factor to make the timer tick.
// Assumes: The source tick is a one-cycle pulse on CLK, or held high for the I/O clock.
// Notes:   The tick output is combinational and lasts one CLK cycle.
module tick_prescaler
	import tc_pkg::*;
#(
	parameter int DIV_W = 10
)
(
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             src_tick,
	input  wire logic [2:0]       clk_sel,
	output logic                  timer_tick
);

	logic [DIV_W-1:0] div_r;   // Free-running source tick counter.
	logic [DIV_W-1:0] div_nxt; // Next value of the counter.
	logic [DIV_W-1:0] mask;    // Counter bits that must all be one for a tick.

	// Maps a clock select code to the counter bits that define its factor.
	function automatic logic [DIV_W-1:0] tap_mask(input logic [2:0] sel);
		case (sel)
			3'h1:    tap_mask = DIV_W'(PRE_MASK_1);
			3'h2:    tap_mask = DIV_W'(PRE_MASK_8);
			3'h3:    tap_mask = DIV_W'(PRE_MASK_32);
			3'h4:    tap_mask = DIV_W'(PRE_MASK_64);
			3'h5:    tap_mask = DIV_W'(PRE_MASK_128);
			3'h6:    tap_mask = DIV_W'(PRE_MASK_256);
			default: tap_mask = DIV_W'(PRE_MASK_1024);
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Counts source ticks and fires when the selected low bits are all ones.
	always_comb
	begin
		mask = tap_mask(clk_sel);
		div_nxt = div_r;
		if (src_tick)
		begin
			div_nxt = div_r + DIV_W'(1);
		end
		timer_tick = src_tick && (clk_sel != CLK_STOP) && ((div_r & mask) == mask);
	end

	// Registers the counter.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			div_r <= DIV_W'(RST_PRE);
		end
		else
		begin
			div_r <= div_nxt;
		end
	end

endmodule

// *** async_dual_slope_pwm_timer.sv ***
// Purpose: Eight-bit timer with dual-slope PWM on two outputs and oscillator clocking.
// Assumes: The oscillator pin toggles much slower than CLK and is sampled on CLK.
// Notes:   Other wave modes only count up and wrap; their outputs are left unchanged.

module async_dual_slope_pwm_timer
	import tc_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       RESET_N,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       OSC_CLOCK_PIN,
	input  wire logic       SLEEP_ACTIVE,
	output logic            COMPARE_OUT_A,
	output logic            COMPARE_OUT_B,
	output logic            OUT_CONNECT_A,
	output logic            OUT_CONNECT_B,
	output logic            OSC_PINS_DETACHED,
	output logic            IRQ,
	output logic            WAKE_REQ
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic       osc_s1_r, osc_s1_nxt;         // First synchroniser stage.
	logic       osc_s2_r, osc_s2_nxt;         // Second synchroniser stage.
	logic       osc_s3_r, osc_s3_nxt;         // Delayed copy for edge detection.
	logic       osc_rise;                     // One-cycle pulse per oscillator rising edge.
	logic [7:0] hold_r   [0:NUM_SLOTS-1];     // Holding registers for oscillator writes.
	logic [7:0] hold_nxt [0:NUM_SLOTS-1];
	logic [1:0] edges_r  [0:NUM_SLOTS-1];     // Oscillator edges seen since the write.
	logic [1:0] edges_nxt[0:NUM_SLOTS-1];
	logic [NUM_SLOTS-1:0] pend_r, pend_nxt;   // Update-busy flags.
	logic [NUM_SLOTS-1:0] commit_v;           // Slot commits this cycle.
	logic [7:0] commit_d [0:NUM_SLOTS-1];     // Value committed per slot.
	logic [2:0] wr_slot;                      // Slot addressed by a write.
	logic       async_r, async_nxt;           // Oscillator clock selected.
	logic       src_tick;                     // Prescaler source pulse.
	logic       tick;                         // Timer tick from the prescaler.
	logic [7:0] ctrl_a_r, ctrl_a_nxt;         // First control register.
	logic [7:0] ctrl_b_r, ctrl_b_nxt;         // Second control register.
	logic [7:0] buf_a_r, buf_a_nxt;           // Compare A as written.
	logic [7:0] buf_b_r, buf_b_nxt;           // Compare B as written.
	logic [7:0] act_a_r, act_a_nxt;           // Compare A in use.
	logic [7:0] act_b_r, act_b_nxt;           // Compare B in use.
	logic [7:0] count_r, count_nxt;           // Counter value.
	logic [7:0] rd_count_r, rd_count_nxt;     // Counter copy taken on oscillator edges.
	dir_e       dir_r, dir_nxt;               // Counting direction.
	logic       out_a_r, out_a_nxt;           // Compare output A.
	logic       out_b_r, out_b_nxt;           // Compare output B.
	logic [2:0] ev;                           // Events raised on this tick.
	logic [2:0] wave_mode_sel;                // Mode select field.
	logic       dual;                         // Dual-slope mode active.
	logic [7:0] top;                          // Current top value.
	logic       cmp_block;                    // Compare matching suspended.
	logic [2:0] evd_r  [0:IRQ_SYNC_CYCLES-1]; // Flag crossing delay line.
	logic [2:0] evd_nxt[0:IRQ_SYNC_CYCLES-1];
	logic [2:0] flags_r, flags_nxt;           // Overflow and compare flags.
	logic [2:0] mask_r, mask_nxt;             // Flag enables.
	logic [2:0] set_v;                        // Flags set this cycle.
	logic [2:0] clr_v;                        // Flags cleared by software this cycle.
	logic       wake_arm_r, wake_arm_nxt;     // Enabled event seen while asleep.
	logic       wake_r, wake_nxt;             // Wake request.
	logic [7:0] rdata_r, rdata_nxt;           // Read data register.

	// Returns the holding slot of an address, or none.
	function automatic logic [2:0] slot_of(input logic [7:0] a);
		if (a == OFS_COUNT)
			slot_of = SLOT_COUNT;
		else if (a == OFS_CMP_A)
			slot_of = SLOT_CMP_A;
		else if (a == OFS_CMP_B)
			slot_of = SLOT_CMP_B;
		else if (a == OFS_CTRL_A)
			slot_of = SLOT_CTRL_A;
		else if (a == OFS_CTRL_B)
			slot_of = SLOT_CTRL_B;
		else
			slot_of = SLOT_NONE;
	endfunction

	// Next level of one compare output in dual-slope mode.
	function automatic logic pwm_level(input logic cur, input logic [1:0] sel,
		input logic [7:0] cmp, input logic [7:0] cnt, input logic [7:0] tp,
		input logic up, input logic blk);
		logic up_lvl;
		up_lvl = (sel == ACT_SET_UP);
		pwm_level = cur;
		if (sel == ACT_CLEAR_UP || sel == ACT_SET_UP)
		begin
			// At top a compare at or above top holds the down level, else the up level.
			if (up && cnt >= tp)
				pwm_level = (cmp >= tp) ? !up_lvl : up_lvl;
			// At bottom the new period starts from the level before the up match, unless compare is zero.
			else if (!up && cnt == BOTTOM)
				pwm_level = (cmp == BOTTOM) ? up_lvl : !up_lvl;
			else if (cnt == cmp && !blk)
				pwm_level = up ? up_lvl : !up_lvl;
		end
		return pwm_level;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Oscillator sampling and holding registers for writes.
	assign osc_rise = osc_s2_r && !osc_s3_r;
	assign wr_slot  = WR ? slot_of(ADDR) : SLOT_NONE;

	// Computes synchroniser, busy flags and the commit of each register.
	always_comb
	begin
		osc_s1_nxt = OSC_CLOCK_PIN;
		osc_s2_nxt = osc_s1_r;
		osc_s3_nxt = osc_s2_r;
		pend_nxt   = pend_r;
		commit_v   = '0;
		for (int i = 0; i < NUM_SLOTS; i++)
		begin
			hold_nxt[i]  = hold_r[i];
			edges_nxt[i] = edges_r[i];
			commit_d[i]  = hold_r[i];
		end
		if (!async_r)
		begin
			// On the I/O clock a write lands in the next cycle.
			pend_nxt = '0;
			if (wr_slot != SLOT_NONE)
			begin
				commit_v[wr_slot] = 1'b1;
				commit_d[wr_slot] = WDATA;
			end
		end
		else
		begin
			// Each slot counts its own oscillator edges and commits on the second.
			for (int i = 0; i < NUM_SLOTS; i++)
			begin
				if (pend_r[i] && osc_rise)
				begin
					if (edges_r[i] == COMMIT_EDGES - 2'h1)
					begin
						commit_v[i] = 1'b1;
						pend_nxt[i] = 1'b0;
					end
					else
					begin
						edges_nxt[i] = edges_r[i] + 2'h1;
					end
				end
			end
			// A write to a busy slot is dropped so the transfer in flight survives.
			if (wr_slot != SLOT_NONE && !pend_r[wr_slot])
			begin
				hold_nxt[wr_slot]  = WDATA;
				edges_nxt[wr_slot] = 2'h0;
				pend_nxt[wr_slot]  = 1'b1;
			end
		end
	end

	// Registers the synchroniser and the holding slots.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
			pend_r   <= '0;
			for (int i = 0; i < NUM_SLOTS; i++)
			begin
				hold_r[i]  <= RST_BYTE;
				edges_r[i] <= 2'h0;
			end
		end
		else
		begin
			osc_s1_r <= osc_s1_nxt;
			osc_s2_r <= osc_s2_nxt;
			osc_s3_r <= osc_s3_nxt;
			pend_r   <= pend_nxt;
			for (int i = 0; i < NUM_SLOTS; i++)
			begin
				hold_r[i]  <= hold_nxt[i];
				edges_r[i] <= edges_nxt[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Prescaler: the oscillator edge replaces the I/O clock as source.
	assign src_tick = async_r ? osc_rise : 1'b1;

	tick_prescaler #(
		.DIV_W      (10)
	) u_prescaler (
		.clk        (CLK),
		.reset_n    (RESET_N),
		.src_tick   (src_tick),
		.clk_sel    (ctrl_b_r[CLK_SEL_LSB +: 3]),
		.timer_tick (tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Counter, compare units and outputs.
	assign wave_mode_sel = {ctrl_b_r[WAVE_HI_BIT], ctrl_a_r[WAVE_LO_LSB +: 2]};
	assign dual = (wave_mode_sel == WAVE_DUAL_MAX) || (wave_mode_sel == WAVE_DUAL_CMPA);
	assign top  = (wave_mode_sel == WAVE_DUAL_CMPA) ? act_a_r : TOP_MAX;
	assign cmp_block = async_r && (pend_r[SLOT_COUNT] || pend_r[SLOT_CMP_A] || pend_r[SLOT_CMP_B]);

	// Steps the counter on each tick and updates compares and outputs.
	always_comb
	begin
		ctrl_a_nxt   = commit_v[SLOT_CTRL_A] ? commit_d[SLOT_CTRL_A] : ctrl_a_r;
		ctrl_b_nxt   = commit_v[SLOT_CTRL_B] ? commit_d[SLOT_CTRL_B] : ctrl_b_r;
		buf_a_nxt    = commit_v[SLOT_CMP_A] ? commit_d[SLOT_CMP_A] : buf_a_r;
		buf_b_nxt    = commit_v[SLOT_CMP_B] ? commit_d[SLOT_CMP_B] : buf_b_r;
		act_a_nxt    = dual ? act_a_r : buf_a_nxt;
		act_b_nxt    = dual ? act_b_r : buf_b_nxt;
		count_nxt    = count_r;
		dir_nxt      = dir_r;
		out_a_nxt    = out_a_r;
		out_b_nxt    = out_b_r;
		rd_count_nxt = rd_count_r;
		ev           = 3'h0;
		if (tick)
		begin
			if (dual && dir_r == DIR_UP && count_r >= top)
			begin
				// Top lasted one tick; turn round and load the new compares.
				count_nxt = (count_r == BOTTOM) ? BOTTOM : count_r - 8'h01;
				dir_nxt   = DIR_DOWN;
				act_a_nxt = buf_a_r;
				act_b_nxt = buf_b_r;
			end
			else if (dual && dir_r == DIR_DOWN && count_r == BOTTOM)
			begin
				count_nxt = count_r + 8'h01;
				dir_nxt   = DIR_UP;
			end
			else if (dual && dir_r == DIR_DOWN)
			begin
				count_nxt = count_r - 8'h01;
				ev[FLAG_OVF] = (count_r == 8'h01);
			end
			else
			begin
				count_nxt = count_r + 8'h01;
				ev[FLAG_OVF] = !dual && (count_r == TOP_MAX);
			end
			ev[FLAG_CMP_A] = !cmp_block && (count_r == act_a_r);
			ev[FLAG_CMP_B] = !cmp_block && (count_r == act_b_r);
			if (dual)
			begin
				// Outputs move on the tick only, never on a bus access.
				out_a_nxt = pwm_level(out_a_r, ctrl_a_r[ACT_A_LSB +: 2], act_a_r, count_r,
					top, dir_r == DIR_UP, cmp_block);
				out_b_nxt = pwm_level(out_b_r, ctrl_a_r[ACT_B_LSB +: 2], act_b_r, count_r,
					top, dir_r == DIR_UP, cmp_block);
			end
		end
		// Readback copy is refreshed on every oscillator edge in oscillator mode.
		if (async_r && osc_rise)
		begin
			rd_count_nxt = count_r;
		end
		// A committed counter write wins over the tick.
		if (commit_v[SLOT_COUNT])
		begin
			count_nxt = commit_d[SLOT_COUNT];
		end
	end

	// Registers the timer state.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			ctrl_a_r   <= RST_BYTE;
			ctrl_b_r   <= RST_BYTE;
			buf_a_r    <= RST_BYTE;
			buf_b_r    <= RST_BYTE;
			act_a_r    <= RST_BYTE;
			act_b_r    <= RST_BYTE;
			count_r    <= RST_BYTE;
			rd_count_r <= RST_BYTE;
			dir_r      <= DIR_UP;
			out_a_r    <= 1'b0;
			out_b_r    <= 1'b0;
		end
		else
		begin
			ctrl_a_r   <= ctrl_a_nxt;
			ctrl_b_r   <= ctrl_b_nxt;
			buf_a_r    <= buf_a_nxt;
			buf_b_r    <= buf_b_nxt;
			act_a_r    <= act_a_nxt;
			act_b_r    <= act_b_nxt;
			count_r    <= count_nxt;
			rd_count_r <= rd_count_nxt;
			dir_r      <= dir_nxt;
			out_a_r    <= out_a_nxt;
			out_b_r    <= out_b_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags, wake request and register reads.
	assign set_v = async_r ? evd_r[IRQ_SYNC_CYCLES-1] : ev;
	assign clr_v = (WR && ADDR == OFS_INT_FLAGS) ? WDATA[2:0] : 3'h0;

	// Computes flags, enables, wake and the read data.
	always_comb
	begin
		evd_nxt[0] = ev;
		for (int i = 1; i < IRQ_SYNC_CYCLES; i++)
		begin
			evd_nxt[i] = evd_r[i-1];
		end
		// A flag set in the cycle of its clear stays set.
		flags_nxt    = (flags_r & ~clr_v) | set_v;
		mask_nxt     = (WR && ADDR == OFS_INT_MASK) ? WDATA[2:0] : mask_r;
		async_nxt    = (WR && ADDR == OFS_ASYNC) ? WDATA[ASYNC_SEL_BIT] : async_r;
		wake_arm_nxt = wake_arm_r;
		wake_nxt     = wake_r;
		if (SLEEP_ACTIVE && |(set_v & mask_r))
		begin
			wake_arm_nxt = 1'b1;
		end
		// The wake request starts on the tick after the event.
		if (wake_arm_r && tick)
		begin
			wake_nxt     = 1'b1;
			wake_arm_nxt = 1'b0;
		end
		if (!SLEEP_ACTIVE)
		begin
			wake_nxt     = 1'b0;
			wake_arm_nxt = 1'b0;
		end
		// Read data stands for one cycle and is zero otherwise.
		rdata_nxt = 8'h00;
		if (RD)
		begin
			if (ADDR == OFS_CTRL_A)
				rdata_nxt = ctrl_a_r;
			else if (ADDR == OFS_CTRL_B)
				rdata_nxt = ctrl_b_r;
			else if (ADDR == OFS_COUNT)
				rdata_nxt = async_r ? rd_count_r : count_r;
			else if (ADDR == OFS_CMP_A)
				rdata_nxt = buf_a_r;
			else if (ADDR == OFS_CMP_B)
				rdata_nxt = buf_b_r;
			else if (ADDR == OFS_ASYNC)
				rdata_nxt = {2'h0, async_r, pend_r};
			else if (ADDR == OFS_INT_FLAGS)
				rdata_nxt = {5'h00, flags_r};
			else if (ADDR == OFS_INT_MASK)
				rdata_nxt = {5'h00, mask_r};
		end
	end

	// Registers flags and bus state.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			for (int i = 0; i < IRQ_SYNC_CYCLES; i++)
			begin
				evd_r[i] <= RST_FLAGS;
			end
			flags_r    <= RST_FLAGS;
			mask_r     <= RST_FLAGS;
			async_r    <= 1'b0;
			wake_arm_r <= 1'b0;
			wake_r     <= 1'b0;
			rdata_r    <= RST_BYTE;
		end
		else
		begin
			for (int i = 0; i < IRQ_SYNC_CYCLES; i++)
			begin
				evd_r[i] <= evd_nxt[i];
			end
			flags_r    <= flags_nxt;
			mask_r     <= mask_nxt;
			async_r    <= async_nxt;
			wake_arm_r <= wake_arm_nxt;
			wake_r     <= wake_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	// Output drive.
	assign RDATA             = rdata_r;
	assign COMPARE_OUT_A     = out_a_r;
	assign COMPARE_OUT_B     = out_b_r;
	assign OUT_CONNECT_A     = (ctrl_a_r[ACT_A_LSB +: 2] != 2'h0);
	assign OUT_CONNECT_B     = (ctrl_a_r[ACT_B_LSB +: 2] != 2'h0);
	assign OSC_PINS_DETACHED = async_r;
	assign IRQ               = |(flags_r & mask_r);
	assign WAKE_REQ          = wake_r;

endmodule

// *** timer_props.sv ***
// Purpose: Port checks for the dual-slope PWM timer.
// Assumes: The oscillator pin stays high for several CLK cycles after it rises.
// Notes:   Busy flags show only through reads, so the bench judges them.
module timer_props
	import tc_pkg::*;
(
	input wire logic       CLK,
	input wire logic       RESET_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       OSC_CLOCK_PIN,
	input wire logic       SLEEP_ACTIVE,
	input wire logic       COMPARE_OUT_A,
	input wire logic       COMPARE_OUT_B,
	input wire logic       OUT_CONNECT_A,
	input wire logic       OUT_CONNECT_B,
	input wire logic       OSC_PINS_DETACHED,
	input wire logic       IRQ,
	input wire logic       WAKE_REQ
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	logic wa; // A write to the status register.
	logic wc; // A write to the first control register in synchronous mode.
	assign wa = WR && ADDR == OFS_ASYNC;
	assign wc = WR && ADDR == OFS_CTRL_A && !OSC_PINS_DETACHED;
	property p_det; wa |=> OSC_PINS_DETACHED == $past(WDATA[ASYNC_SEL_BIT]); endproperty
	a_det: assert property (p_det) else $error("detach level differs from write");
	property p_hold; !wa |=> $stable(OSC_PINS_DETACHED); endproperty
	a_hold: assert property (p_hold) else $error("detach level moved alone");
	property p_pa; wc |=> OUT_CONNECT_A == ($past(WDATA[ACT_A_LSB +: 2]) != 2'h0); endproperty
	a_pa: assert property (p_pa) else $error("output A override wrong");
	property p_pb; wc |=> OUT_CONNECT_B == ($past(WDATA[ACT_B_LSB +: 2]) != 2'h0); endproperty
	a_pb: assert property (p_pb) else $error("output B override wrong");
	// In oscillator mode an output may only move just after a pin rise.
	property p_ta; OSC_PINS_DETACHED && $past(OSC_PINS_DETACHED) && $changed(COMPARE_OUT_A)
		|-> $past(OSC_CLOCK_PIN); endproperty
	a_ta: assert property (p_ta) else $error("output A moved off the tick");
	property p_tb; OSC_PINS_DETACHED && $past(OSC_PINS_DETACHED) && $changed(COMPARE_OUT_B)
		|-> $past(OSC_CLOCK_PIN); endproperty
	a_tb: assert property (p_tb) else $error("output B moved off the tick");
	property p_wk; $rose(WAKE_REQ) |-> $past(SLEEP_ACTIVE) && IRQ; endproperty
	a_wk: assert property (p_wk) else $error("wake without sleep and request");
	property p_wf; $fell(SLEEP_ACTIVE) |=> !WAKE_REQ; endproperty
	a_wf: assert property (p_wf) else $error("wake held after sleep ended");
	property p_mk; WR && ADDR == OFS_INT_MASK && WDATA == 8'h00 |=> !IRQ; endproperty
	a_mk: assert property (p_mk) else $error("request seen with all enables off");
	c_wake: cover property ($rose(WAKE_REQ));
	c_pwm: cover property ($rose(COMPARE_OUT_A));
	c_irq: cover property ($rose(IRQ));
endmodule
bind async_dual_slope_pwm_timer timer_props u_props (.CLK(CLK), .RESET_N(RESET_N),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .OSC_CLOCK_PIN(OSC_CLOCK_PIN),
	.SLEEP_ACTIVE(SLEEP_ACTIVE), .COMPARE_OUT_A(COMPARE_OUT_A), .COMPARE_OUT_B(COMPARE_OUT_B),
	.OUT_CONNECT_A(OUT_CONNECT_A), .OUT_CONNECT_B(OUT_CONNECT_B),
	.OSC_PINS_DETACHED(OSC_PINS_DETACHED), .IRQ(IRQ), .WAKE_REQ(WAKE_REQ));

// *** tb_top.sv ***
// Purpose: Self-checking bench for the dual-slope PWM timer.
// Assumes: Bus strobes change right after rising CLK edges.
// Notes:   The oscillator pin toggles every 8 CLK cycles while enabled.
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_top
	import tc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       CLK = 0, RESET_N = 0, WR = 0, RD = 0, osc = 0, sleep = 0, osc_en = 0;
	logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
	logic       oa, ob, irq, wake;
	logic [3:0] oc = 4'h0;
	int         num_errors = 0, checks = 0;
	async_dual_slope_pwm_timer u_dut (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .OSC_CLOCK_PIN(osc),
		.SLEEP_ACTIVE(sleep), .COMPARE_OUT_A(oa), .COMPARE_OUT_B(ob), .OUT_CONNECT_A(),
		.OUT_CONNECT_B(), .OSC_PINS_DETACHED(), .IRQ(irq), .WAKE_REQ(wake));
	initial forever #25 CLK = ~CLK;
	// Oscillator pin at one sixteenth of CLK, still while disabled.
	always @(posedge CLK)
	begin
		oc <= oc + 4'h1;
		osc <= osc_en & oc[3];
	end
	task automatic results();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
		#1 d = RDATA;
	endtask
	// Counts cycles up to the next rise of output A.
	task automatic rise(output int n);
		logic p;
		p = oa;
		for (n = 1; n < 9000; n++)
		begin
			@(posedge CLK);
			#1;
			if (oa === 1'b1 && p === 1'b0)
				return;
			p = oa;
		end
		num_errors++;
		results();
	endtask
	// Polls the status register until no transfer is pending.
	task automatic wait_idle();
		logic [7:0] s;
		int j;
		s = 8'hFF;
		for (j = 0; j < 100 && s[4:0] !== 5'h00; j++)
			rd(OFS_ASYNC, s);
		`CHK("busy clear", 5'h00, s[4:0])
		if (s[4:0] !== 5'h00)
			results();
	endtask
	task automatic t_regs();
		logic [7:0] d;
		rd(OFS_ASYNC, d);
		`CHK("status", RST_BYTE, d)
		wr(OFS_CMP_A, 8'h5A);
		rd(OFS_CMP_A, d);
		`CHK("cmp a", 8'h5A, d)
		wr(OFS_COUNT, 8'h42);
		rd(OFS_COUNT, d);
		`CHK("count", 8'h42, d)
		$display("regs done");
	endtask
	task automatic t_pwm();
		logic [7:0] d;
		logic [7:0] mx;
		int n;
		int i;
		int bad;
		wr(OFS_CTRL_B, 8'h01);
		wr(OFS_CMP_A, 8'h80);
		wr(OFS_CMP_B, 8'h80);
		wr(OFS_CTRL_A, 8'hB1);
		wr(OFS_INT_FLAGS, 8'h07);
		rise(n);
		rise(n);
		`CHK("period", PERIOD_TICKS_MAX, n)
		`CHK("b inverse", ~oa, ob)
		rd(OFS_INT_FLAGS, d);
		`CHK("ovf", 1'b1, d[FLAG_OVF])
		wr(OFS_CTRL_B, 8'h02);
		rise(n);
		rise(n);
		rise(n);
		`CHK("period 8", 8 * PERIOD_TICKS_MAX, n)
		// Mode five: top comes from compare A; reads three cycles apart hit every phase.
		wr(OFS_CTRL_B, 8'h09);
		wr(OFS_CMP_A, 8'h40);
		repeat (600) @(posedge CLK);
		mx = 8'h00;
		bad = 0;
		for (i = 0; i < 130; i++)
		begin
			rd(OFS_COUNT, d);
			@(posedge CLK);
			bad += (d > 8'h40);
			if (d > mx)
				mx = d;
		end
		`CHK("mode 5 over top", 0, bad)
		`CHK("mode 5 top", 8'h40, mx)
		$display("pwm done");
	endtask
	task automatic t_ext();
		int i, k, ba, bb;
		wr(OFS_CTRL_B, 8'h01);
		wr(OFS_CMP_A, 8'h00);
		wr(OFS_CMP_B, 8'hFF);
		for (k = 0; k < 2; k++)
		begin
			wr(OFS_CTRL_A, k ? 8'hF1 : 8'hA1);
			repeat (1100) @(posedge CLK);
			ba = 0;
			bb = 0;
			for (i = 0; i < 520; i++)
			begin
				@(posedge CLK);
				#1;
				ba += (oa !== k[0]);
				bb += (ob !== !k[0]);
			end
			`CHK("steady a", 0, ba)
			`CHK("steady b", 0, bb)
		end
		$display("extremes done");
	endtask
	task automatic t_async();
		logic [7:0] d;
		int i;
		osc_en <= 1'b1;
		wr(OFS_ASYNC, 8'h20);
		wr(OFS_CMP_A, 8'h33);
		wr(OFS_CMP_B, 8'h44);
		rd(OFS_ASYNC, d);
		`CHK("busy", 2'h3, d[3:2])
		wait_idle();
		rd(OFS_CMP_A, d);
		`CHK("async a", 8'h33, d)
		rd(OFS_CMP_B, d);
		`CHK("async b", 8'h44, d)
		wr(OFS_INT_FLAGS, 8'h07);
		wr(OFS_INT_MASK, 8'h01);
		sleep <= 1'b1;
		for (i = 0; i < 20000 && wake !== 1'b1; i++)
		begin
			@(posedge CLK);
			#1;
		end
		`CHK("wake", 1'b1, wake)
		`CHK("irq", 1'b1, irq)
		if (wake !== 1'b1)
			results();
		sleep <= 1'b0;
		repeat (2) @(posedge CLK);
		`CHK("wake end", 1'b0, wake)
		// After wake the registers are rewritten; the clock is stopped to freeze the count.
		wr(OFS_CTRL_B, 8'h00);
		wait_idle();
		wr(OFS_COUNT, 8'h42);
		wait_idle();
		// A further committed write guarantees an oscillator edge refreshed the readback.
		wr(OFS_CMP_A, 8'h33);
		wait_idle();
		rd(OFS_COUNT, d);
		`CHK("async count", 8'h42, d)
		wr(OFS_INT_MASK, 8'h00);
		wr(OFS_ASYNC, 8'h00);
		$display("async done");
	endtask
	initial
	begin
		repeat (3) @(posedge CLK);
		RESET_N <= 1'b1;
		t_regs();
		t_pwm();
		t_ext();
		t_async();
		results();
	end
endmodule
